// ---- hdl/bmf_map.svh ----
// widths, reset values and counts of the block memory with fifo
`ifndef BMF_MAP_SVH
`define BMF_MAP_SVH
`define BMF_UNIT_W 9
`define BMF_WORD_W 72
`define BMF_ADDR_W 15
`define BMF_ECC_DW 64
`define BMF_NUM_UNITS 4096
`define BMF_UNITS_FULL 13'h1000
`define BMF_UNITS_HALF 13'h0800
`define BMF_DATA_RST 72'h0
`define BMF_CNT_RST 13'h0000
`define BMF_PTR_RST 12'h000
`endif

// ---- hdl/bmf_pkg.sv ----
// types shared by the block memory with fifo controller
package bmf_pkg;
	// port shapes, narrowest first; order is used for clamping
	typedef enum logic [2:0] {
		BMF_W1, BMF_W2, BMF_W4, BMF_W9, BMF_W18, BMF_W36, BMF_W72
	} bmf_width_t;
	// data output behaviour during a write
	typedef enum logic [1:0] {
		BMF_RD_FIRST, BMF_WR_FIRST, BMF_NO_CHANGE
	} bmf_wmode_t;
endpackage

// ---- hdl/bmf_block_mem.sv ----
// dual port block memory with split mode, ecc and fifo controller
// Functional notes
// - one 36Kb array, two independent ports sharing only stored data
// - array works as one 36Kb memory or two independent 18Kb halves
// - all accesses clocked; data, address, enables, write enables registered
// - address held until next operation; latching can be switched off
// - optional output register adds one cycle of read latency
// - on write, output shows old data, new data, or holds
// - dedicated sleep input powers the memory down
// - full memory shapes 32Kx1 up to 512x72, parity-free variants
// - outside split mode the two ports may use different shapes freely
// - each half supports 16Kx1 up to 512x36, otherwise identical
// - wide words above 18 or 36 bits only in split mode
// - split mode: one port only writes, the other only reads
// - split mode: write side fixed 36 or 72 bits, read side variable
// - 64-bit words get eight hamming bits; single fixed, double flagged
// - encoder and decoder usable standalone for external wide memories
// - fifo of 36Kb or 18Kb, here from the single clock
// - fifo moves its own pointers; full, empty, almost flags
// - almost flags follow user occupancy thresholds
// - fifo depth and width set by shape; write and read widths differ
// - cascade path carries read data between adjacent memories
`include "bmf_map.svh"
`timescale 1ns/10ps
`default_nettype none
module bmf_block_mem import bmf_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// configuration
	input wire logic half_mode,
	input wire logic split_read_write_mode,
	input wire logic fifo_mode,
	input wire logic ecc_en,
	input wire logic out_reg_en,
	input wire logic addr_latch_en,
	input wire logic sleep,
	input wire bmf_width_t width_a,
	input wire bmf_width_t width_b,
	input wire bmf_wmode_t wmode_a,
	input wire bmf_wmode_t wmode_b,
	input wire logic half_sel_a,
	input wire logic half_sel_b,
	input wire logic [12:0] afull_thresh,
	input wire logic [12:0] aempty_thresh,
	// port a
	input wire logic en_a,
	input wire logic we_a,
	input wire logic [`BMF_ADDR_W-1:0] addr_a,
	input wire logic [`BMF_WORD_W-1:0] din_a,
	output logic [`BMF_WORD_W-1:0] dout_a,
	// port b
	input wire logic en_b,
	input wire logic we_b,
	input wire logic [`BMF_ADDR_W-1:0] addr_b,
	input wire logic [`BMF_WORD_W-1:0] din_b,
	output logic [`BMF_WORD_W-1:0] dout_b,
	// fifo and error flags
	output logic fifo_full,
	output logic fifo_empty,
	output logic fifo_afull,
	output logic fifo_aempty,
	output logic ecc_sbe,
	output logic ecc_dbe,
	// cascade
	input wire logic casc_use,
	input wire logic [`BMF_WORD_W-1:0] casc_din,
	output logic [`BMF_WORD_W-1:0] casc_dout,
	// standalone ecc
	input wire logic [`BMF_ECC_DW-1:0] enc_din,
	output logic [`BMF_WORD_W-1:0] enc_dout,
	input wire logic [`BMF_WORD_W-1:0] dec_din,
	output logic [`BMF_ECC_DW-1:0] dec_dout,
	output logic dec_sbe,
	output logic dec_dbe
);

	// ********************************
	// helper functions
	// ********************************
	function automatic logic [3:0] w_units(bmf_width_t w);
		case (w)
			BMF_W18: return 4'h2;
			BMF_W36: return 4'h4;
			BMF_W72: return 4'h8;
			default: return 4'h1;
		endcase
	endfunction

	function automatic logic [7:0] w_submask(bmf_width_t w);
		case (w)
			BMF_W1: return 8'h01;
			BMF_W2: return 8'h03;
			BMF_W4: return 8'h0F;
			default: return 8'h00;
		endcase
	endfunction

	// word address to first 9-bit unit and bit offset inside it
	function automatic logic [11:0] to_unit(logic [14:0] a, bmf_width_t w);
		case (w)
			BMF_W1: return a[14:3];
			BMF_W2: return a[13:2];
			BMF_W4: return a[12:1];
			BMF_W9: return a[11:0];
			BMF_W18: return {a[10:0], 1'b0};
			BMF_W36: return {a[9:0], 2'b0};
			default: return {a[8:0], 3'b0};
		endcase
	endfunction

	function automatic logic [2:0] to_off(logic [14:0] a, bmf_width_t w);
		case (w)
			BMF_W1: return a[2:0];
			BMF_W2: return {a[1:0], 1'b0};
			BMF_W4: return {a[0], 2'b0};
			default: return 3'h0;
		endcase
	endfunction

	// a half keeps its own address space; the unit index wraps inside it
	function automatic logic [11:0] uidx(logic [11:0] b, int k, logic h,
		logic s);
		logic [11:0] i;
		i = b + 12'(k);
		return h ? {s, i[10:0]} : i;
	endfunction

	// shape limits: wide words only in split mode, write side fixed there
	function automatic bmf_width_t eff_w(bmf_width_t w, logic h, logic sp,
		logic wside);
		bmf_width_t lim;
		lim = sp ? (h ? BMF_W36 : BMF_W72) : (h ? BMF_W18 : BMF_W36);
		if (sp && wside)
			return lim;
		return (w > lim) ? lim : w;
	endfunction

	function automatic logic [71:0] wsel(bmf_wmode_t m, logic [71:0] o,
		logic [71:0] n, logic [71:0] h);
		case (m)
			BMF_WR_FIRST: return n;
			BMF_NO_CHANGE: return h;
			default: return o;
		endcase
	endfunction

	// hamming: position p of 1..71 in bit p, overall parity in bit 0
	function automatic logic [71:0] ecc_enc(logic [63:0] d);
		logic [71:0] c;
		int j;
		c = '0;
		j = 0;
		for (int i = 1; i < 72; i++) begin
			if ((i & (i - 1)) != 0) begin
				c[i] = d[j];
				j++;
			end
		end
		for (int i = 1; i < 72; i++) begin
			for (int p = 0; p < 7; p++) begin
				if (((i >> p) & 1) == 1 && (i & (i - 1)) != 0)
					c[1 << p] = c[1 << p] ^ c[i];
			end
		end
		c[0] = ^c[71:1];
		return c;
	endfunction

	// returns {double, single, data}
	function automatic logic [65:0] ecc_dec(logic [71:0] c);
		logic [6:0] s;
		logic [71:0] f;
		logic [63:0] d;
		logic sb;
		logic db;
		int j;
		s = 7'h00;
		f = c;
		d = '0;
		sb = 1'b0;
		db = 1'b0;
		j = 0;
		for (int i = 1; i < 72; i++) begin
			if (c[i])
				s = s ^ 7'(i);
		end
		if (s != 7'h00 && (^c) && s < 7'h48) begin
			f[s] = ~f[s];
			sb = 1'b1;
		end else if (s != 7'h00) begin
			db = 1'b1;
		end else if (^c) begin
			sb = 1'b1;
		end
		for (int i = 1; i < 72; i++) begin
			if ((i & (i - 1)) != 0) begin
				d[j] = f[i];
				j++;
			end
		end
		return {db, sb, d};
	endfunction

	// ********************************
	// input registers
	// ********************************
	logic en_a_q, we_a_q, en_b_q, we_b_q, sleep_q;
	logic [14:0] addr_a_q, addr_b_q;
	logic [71:0] din_a_q, din_b_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			en_a_q <= 1'b0;
			we_a_q <= 1'b0;
			en_b_q <= 1'b0;
			we_b_q <= 1'b0;
			sleep_q <= 1'b0;
			addr_a_q <= 15'h0000;
			addr_b_q <= 15'h0000;
			din_a_q <= `BMF_DATA_RST;
			din_b_q <= `BMF_DATA_RST;
		end else begin
			en_a_q <= en_a;
			we_a_q <= we_a;
			en_b_q <= en_b;
			we_b_q <= we_b;
			sleep_q <= sleep;
			din_a_q <= din_a;
			din_b_q <= din_b;
			addr_a_q <= en_a ? addr_a : addr_a_q;
			addr_b_q <= en_b ? addr_b : addr_b_q;
		end
	end

	// ********************************
	// decode of both ports
	// ********************************
	logic [11:0] wr_ptr_q, rd_ptr_q;
	logic [12:0] cnt_q;
	logic [71:0] lat_a_q, lat_b_q;
	logic [71:0] rd_a, rd_b;
	logic [`BMF_UNIT_W-1:0] mem [0:`BMF_NUM_UNITS-1];

	wire logic [14:0] ad_a = addr_latch_en ? addr_a_q : addr_a;
	wire logic [14:0] ad_b = addr_latch_en ? addr_b_q : addr_b;
	wire logic split_q = split_read_write_mode | fifo_mode;
	wire bmf_width_t ew_a = eff_w(width_a, half_mode, split_q, 1'b1);
	wire bmf_width_t ew_b = eff_w(width_b, half_mode, split_q, 1'b0);
	wire bmf_width_t fw_a = eff_w(width_a, half_mode, 1'b0, 1'b0);
	wire bmf_width_t use_a = fifo_mode ? fw_a : ew_a;
	wire logic [3:0] nu_a = w_units(use_a);
	wire logic [3:0] nu_b = w_units(ew_b);
	wire logic [7:0] sm_a = w_submask(use_a);
	wire logic [7:0] sm_b = w_submask(ew_b);
	wire logic [2:0] of_a = fifo_mode ? 3'h0 : to_off(ad_a, use_a);
	wire logic [2:0] of_b = fifo_mode ? 3'h0 : to_off(ad_b, ew_b);
	wire logic [11:0] bu_a = fifo_mode ? wr_ptr_q : to_unit(ad_a, use_a);
	wire logic [11:0] bu_b = fifo_mode ? rd_ptr_q : to_unit(ad_b, ew_b);
	wire logic ecc_on = ecc_en & split_read_write_mode & ~half_mode &
		~fifo_mode;

	// ********************************
	// fifo controller
	// ********************************
	wire logic [12:0] cap = half_mode ? `BMF_UNITS_HALF : `BMF_UNITS_FULL;
	wire logic [12:0] cnt_wr = cnt_q + 13'(nu_a);
	wire logic can_wr = cnt_wr <= cap;
	wire logic can_rd = cnt_q >= 13'(nu_b);
	wire logic fwr = fifo_mode & en_a_q & we_a_q & ~sleep_q & can_wr;
	wire logic frd = fifo_mode & en_b_q & ~sleep_q & can_rd;
	wire logic [12:0] cnt_d = cnt_q + (fwr ? 13'(nu_a) : 13'h0000) -
		(frd ? 13'(nu_b) : 13'h0000);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_q <= `BMF_PTR_RST;
			rd_ptr_q <= `BMF_PTR_RST;
			cnt_q <= `BMF_CNT_RST;
			fifo_full <= 1'b0;
			fifo_empty <= 1'b1;
			fifo_afull <= 1'b0;
			fifo_aempty <= 1'b1;
		end else begin
			wr_ptr_q <= fwr ? wr_ptr_q + 12'(nu_a) : wr_ptr_q;
			rd_ptr_q <= frd ? rd_ptr_q + 12'(nu_b) : rd_ptr_q;
			cnt_q <= cnt_d;
			fifo_full <= fifo_mode & (cnt_d + 13'(nu_a) > cap);
			fifo_empty <= cnt_d < 13'(nu_b);
			fifo_afull <= cnt_d >= afull_thresh;
			fifo_aempty <= cnt_d <= aempty_thresh;
		end
	end

	// ********************************
	// array access
	// ********************************
	// sleep freezes both ports; contents kept, outputs hold
	wire logic act_a = en_a_q & ~sleep_q;
	wire logic act_b = en_b_q & ~sleep_q;
	wire logic wr_a = fifo_mode ? fwr : act_a & we_a_q;
	wire logic rdo_a = act_a & ~we_a_q & ~split_q;
	wire logic wr_b = act_b & we_b_q & ~split_q;
	wire logic rdo_b = fifo_mode ? frd : act_b & (split_q | ~we_b_q);

	always_comb begin
		rd_a = '0;
		rd_b = '0;
		for (int k = 0; k < 8; k++) begin
			if (4'(k) < nu_a)
				rd_a[9*k +: 9] = mem[uidx(bu_a, k, half_mode, half_sel_a)];
			if (4'(k) < nu_b)
				rd_b[9*k +: 9] = mem[uidx(bu_b, k, half_mode, half_sel_b)];
		end
	end

	// sub-unit shapes read-modify-write one unit, parity bit kept
	wire logic [7:0] pm_a = sm_a << of_a;
	wire logic [7:0] pm_b = sm_b << of_b;
	wire logic [7:0] nb_a = (rd_a[7:0] & ~pm_a) | ((din_a_q[7:0] & sm_a) << of_a);
	wire logic [7:0] nb_b = (rd_b[7:0] & ~pm_b) | ((din_b_q[7:0] & sm_b) << of_b);
	wire logic [71:0] wv_a = ecc_on ? ecc_enc(din_a_q[63:0]) :
		(sm_a != 8'h00) ? {din_a_q[71:9], rd_a[8], nb_a} : din_a_q;
	wire logic [71:0] wv_b = (sm_b != 8'h00) ?
		{din_b_q[71:9], rd_b[8], nb_b} : din_b_q;

	always_ff @(posedge clk) begin
		for (int k = 0; k < 8; k++) begin
			if (wr_a && 4'(k) < nu_a)
				mem[uidx(bu_a, k, half_mode, half_sel_a)] <= wv_a[9*k +: 9];
			if (wr_b && 4'(k) < nu_b)
				mem[uidx(bu_b, k, half_mode, half_sel_b)] <= wv_b[9*k +: 9];
		end
	end

	// ********************************
	// read data and output stage
	// ********************************
	wire logic [65:0] dc_b = ecc_dec(rd_b);
	wire logic ecc_rd = ecc_on & (ew_b == BMF_W72);
	wire logic [71:0] sv_a = 72'((rd_a[7:0] >> of_a) & sm_a);
	wire logic [71:0] sv_b = 72'((rd_b[7:0] >> of_b) & sm_b);
	wire logic [71:0] vw_a = (sm_a != 8'h00) ? sv_a : rd_a;
	wire logic [71:0] vw_b = ecc_rd ? {8'h00, dc_b[63:0]} :
		(sm_b != 8'h00) ? sv_b : rd_b;
	wire logic [71:0] nw_a = (sm_a != 8'h00) ? 72'(din_a_q[7:0] & sm_a) : din_a_q;
	wire logic [71:0] nw_b = (sm_b != 8'h00) ? 72'(din_b_q[7:0] & sm_b) : din_b_q;
	wire logic [71:0] rv_b = casc_use ? casc_din : vw_b;
	wire logic [71:0] lat_a_d = rdo_a ? vw_a : (wr_a && !split_q) ?
		wsel(wmode_a, vw_a, nw_a, lat_a_q) : lat_a_q;
	wire logic [71:0] lat_b_d = rdo_b ? rv_b : wr_b ?
		wsel(wmode_b, vw_b, nw_b, lat_b_q) : lat_b_q;
	wire logic [65:0] ex_dec = ecc_dec(dec_din);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lat_a_q <= `BMF_DATA_RST;
			lat_b_q <= `BMF_DATA_RST;
			dout_a <= `BMF_DATA_RST;
			dout_b <= `BMF_DATA_RST;
			casc_dout <= `BMF_DATA_RST;
			ecc_sbe <= 1'b0;
			ecc_dbe <= 1'b0;
			enc_dout <= `BMF_DATA_RST;
			dec_dout <= 64'h0;
			dec_sbe <= 1'b0;
			dec_dbe <= 1'b0;
		end else begin
			lat_a_q <= lat_a_d;
			lat_b_q <= lat_b_d;
			// pipeline register trades a cycle for clock rate
			dout_a <= out_reg_en ? lat_a_q : lat_a_d;
			dout_b <= out_reg_en ? lat_b_q : lat_b_d;
			casc_dout <= rdo_b ? vw_b : casc_dout;
			ecc_sbe <= (rdo_b && ecc_rd) ? dc_b[64] : ecc_sbe;
			ecc_dbe <= (rdo_b && ecc_rd) ? dc_b[65] : ecc_dbe;
			enc_dout <= ecc_enc(enc_din);
			dec_dout <= ex_dec[63:0];
			dec_sbe <= ex_dec[64];
			dec_dbe <= ex_dec[65];
		end
	end

endmodule
`default_nettype wire

// ---- sim/bmf_block_mem_assertions.sv ----
// concurrent checks on the ports of the block memory with fifo
`timescale 1ns/10ps
`default_nettype none
module bmf_block_mem_assertions (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// modes and requests
	input wire logic fifo_mode,
	input wire logic split_read_write_mode,
	input wire logic sleep,
	input wire logic en_a,
	input wire logic en_b,
	input wire logic casc_use,
	// watched results
	input wire logic [71:0] dout_a,
	input wire logic [71:0] dout_b,
	input wire logic fifo_full,
	input wire logic fifo_empty,
	input wire logic fifo_aempty,
	input wire logic [63:0] enc_din,
	input wire logic [71:0] enc_dout,
	input wire logic [71:0] dec_din,
	input wire logic [63:0] dec_dout,
	input wire logic dec_sbe,
	input wire logic dec_dbe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ****************
	// sequences
	// ****************
	// three quiet cycles let an op in flight land, out register included
	sequence quiet_b_s;
		(!en_b && !casc_use) [*3];
	endsequence
	sequence asleep_s;
		sleep [*3];
	endsequence
	sequence fifo_idle_s;
		(fifo_mode && !en_a && !en_b) [*3];
	endsequence
	sequence clean_word_s;
		$stable(enc_din) && dec_din == enc_dout;
	endsequence
	// ****************
	// properties
	// ****************
	AST_HOLD_B: assert property (quiet_b_s |=> $stable(dout_b))
		else $error("dout_b moved with no port b operation");
	AST_SLEEP: assert property (asleep_s |=> $stable(dout_b) && $stable(dout_a))
		else $error("output moved while asleep");
	AST_A_WRONLY: assert property ((fifo_mode || split_read_write_mode) [*3] |=> $stable(dout_a))
		else $error("dout_a moved in a write only mode");
	AST_FIFO_RST: assert property ($rose(rst_b) |-> fifo_empty && fifo_aempty && !fifo_full)
		else $error("fifo flags wrong after reset");
	AST_FIFO_STILL: assert property (fifo_idle_s |=> $stable(fifo_full) && $stable(fifo_empty))
		else $error("fifo flags moved with no access");
	AST_ENC_CLEAN: assert property (clean_word_s |=> dec_dout == $past(enc_din) && !dec_sbe && !dec_dbe)
		else $error("clean codeword not decoded");
	AST_ENC_PARITY: assert property (^enc_dout == 1'h0)
		else $error("codeword overall parity odd");
	AST_ECC_FIX: assert property ($stable(enc_din) && $onehot(dec_din ^ enc_dout) |=> dec_sbe && !dec_dbe && dec_dout == $past(enc_din))
		else $error("single bit error not corrected");
	AST_ECC_DBL: assert property ($stable(enc_din) && $countones(dec_din ^ enc_dout) == 2 |=> dec_dbe && !dec_sbe)
		else $error("double bit error not flagged");
endmodule
bind bmf_block_mem bmf_block_mem_assertions bmf_block_mem_assertions_inst (
	.clk, .rst_b, .fifo_mode, .split_read_write_mode, .sleep, .en_a, .en_b,
	.casc_use, .dout_a, .dout_b, .fifo_full, .fifo_empty, .fifo_aempty,
	.enc_din, .enc_dout, .dec_din, .dec_dout, .dec_sbe, .dec_dbe
);
`default_nettype wire

// ---- sim/bmf_fabric_model.sv ----
// user fabric model that issues requests on both memory ports
`timescale 1ns/10ps
`default_nettype none
module bmf_fabric_model (
	// clock
	input wire logic clk,
	// port a
	output logic en_a,
	output logic we_a,
	output logic [14:0] addr_a,
	output logic [71:0] din_a,
	// port b
	output logic en_b,
	output logic [14:0] addr_b
);
	initial begin
		{en_a, we_a, addr_a, din_a, en_b, addr_b} = '0;
	end
	// a request is taken at the one edge that sees its enable high
	task automatic put_a(input logic [14:0] a, input logic [71:0] d);
		@(posedge clk);
		{en_a, we_a, addr_a, din_a} <= {2'h3, a, d};
		@(posedge clk);
		{en_a, we_a} <= 2'h0;
		// stale data must never look valid
		din_a <= ~d;
	endtask
	task automatic get_b(input logic [14:0] a);
		@(posedge clk);
		{en_b, addr_b} <= {1'h1, a};
		@(posedge clk);
		en_b <= 1'h0;
	endtask
endmodule
`default_nettype wire

// ---- sim/bmf_block_mem_tb.sv ----
// self-checking bench for the block memory with fifo
`timescale 1ns/10ps
`default_nettype none
module bmf_block_mem_tb import bmf_pkg::*;;
	typedef struct {int sel; logic [71:0] v;} bmf_note_t;
	logic clk = 1'h0, rst_b = 1'h0, half_mode = 1'h0, fifo_mode = 1'h0;
	logic split_read_write_mode = 1'h0, ecc_en = 1'h0, we_b = 1'h0;
	logic out_reg_en = 1'h0, addr_latch_en = 1'h1, sleep = 1'h0;
	logic half_sel_a = 1'h0, half_sel_b = 1'h0, casc_use = 1'h0;
	bmf_width_t width_a = BMF_W36, width_b = BMF_W18;
	bmf_wmode_t wmode_a = BMF_WR_FIRST, wmode_b = BMF_RD_FIRST;
	logic [12:0] afull_thresh = 13'h0100, aempty_thresh = 13'h0000;
	logic [71:0] din_b = 72'h0, casc_din = 72'h0, dec_din = 72'h0, v0, v1;
	logic [63:0] enc_din = 64'h0, e, dec_dout;
	logic en_a, we_a, en_b, fifo_full, fifo_empty, fifo_afull, fifo_aempty;
	logic ecc_sbe, ecc_dbe, dec_sbe, dec_dbe;
	logic [14:0] addr_a, addr_b;
	logic [71:0] din_a, dout_a, dout_b, casc_dout, enc_dout;
	logic [71:0] flips [3] = '{72'h0, 72'h10_0000_0000, 72'h8_0000_0008};
	logic [35:0] fq[$];
	bmf_note_t notes[$];
	bmf_note_t n;
	int mismatches = 0, check_count = 0, cycles = 0, seed = 4, i, lat;
	bmf_block_mem bmf_block_mem_inst (.clk, .rst_b, .half_mode,
		.split_read_write_mode, .fifo_mode, .ecc_en, .out_reg_en,
		.addr_latch_en, .sleep, .width_a, .width_b, .wmode_a, .wmode_b,
		.half_sel_a, .half_sel_b, .afull_thresh, .aempty_thresh, .en_a,
		.we_a, .addr_a, .din_a, .dout_a, .en_b, .we_b, .addr_b, .din_b,
		.dout_b, .fifo_full, .fifo_empty, .fifo_afull, .fifo_aempty,
		.ecc_sbe, .ecc_dbe, .casc_use, .casc_din, .casc_dout, .enc_din,
		.enc_dout, .dec_din, .dec_dout, .dec_sbe, .dec_dbe);
	bmf_fabric_model bmf_fabric_model_inst (.clk, .en_a, .we_a, .addr_a,
		.din_a, .en_b, .addr_b);
	always #10 clk = ~clk;
	// ****************
	// checking
	// ****************
	function automatic logic [71:0] look(int s);
		case (s)
			0: return dout_a;
			1: return dout_b;
			2: return {68'h0, fifo_full, fifo_empty, fifo_afull, fifo_aempty};
			3: return {6'h0, dec_sbe, dec_dbe, dec_dout};
			4: return {70'h0, dec_sbe, dec_dbe};
			6: return {70'h0, ecc_sbe, ecc_dbe};
			default: return casc_dout;
		endcase
	endfunction
	task automatic note(int s, logic [71:0] v);
		notes.push_back('{s, v});
	endtask
	task automatic tick(int k);
		repeat (k) @(posedge clk);
	endtask
	always @(negedge clk) begin
		while (notes.size() > 0) begin
			n = notes.pop_front();
			check_count++;
			if (look(n.sel) !== n.v) begin
				mismatches++;
				$display("Error at %0t: out %0d %h exp %h", $time, n.sel,
					look(n.sel), n.v);
			end
		end
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// a run of this length is far past any scenario below
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			stop_test();
		end
	end
	// ****************
	// scenarios
	// ****************
	initial begin
		tick(5);
		rst_b <= 1'h1;
		tick(1);
		note(2, 72'h5);
		$display("reset done");
		for (i = 0; i < 6; i++) begin
			out_reg_en <= i[0];
			lat = 1 + i % 2;
			v0 = 72'({$random(seed), $random(seed)}) & 72'hF_FFFF_FFFF;
			v1 = 72'({$random(seed), $random(seed)}) & 72'hF_FFFF_FFFF;
			wmode_a <= BMF_WR_FIRST;
			bmf_fabric_model_inst.put_a(15'(i), v0);
			tick(lat);
			note(0, v0);
			wmode_a <= bmf_wmode_t'(i / 2);
			bmf_fabric_model_inst.put_a(15'(i), v1);
			tick(lat);
			note(0, (i / 2 == 1) ? v1 : v0);
			bmf_fabric_model_inst.get_b(15'(2 * i + 1));
			tick(lat);
			note(1, v1 >> 18);
		end
		$display("shapes and write modes done");
		{out_reg_en, half_mode, half_sel_a, half_sel_b} <= 4'h7;
		width_a <= BMF_W18;
		width_b <= BMF_W18;
		bmf_fabric_model_inst.put_a(15'h5, v0 & 72'h3FFFF);
		// the half select is not registered: hold it until the write lands
		tick(1);
		half_sel_a <= 1'h0;
		bmf_fabric_model_inst.put_a(15'h5, v1);
		bmf_fabric_model_inst.get_b(15'h5);
		tick(1);
		note(1, v0 & 72'h3FFFF);
		half_mode <= 1'h0;
		width_a <= BMF_W36;
		width_b <= BMF_W36;
		bmf_fabric_model_inst.put_a(15'h0, v0);
		sleep <= 1'h1;
		bmf_fabric_model_inst.put_a(15'h0, v1);
		tick(2);
		{sleep, addr_latch_en} <= 2'h0;
		bmf_fabric_model_inst.get_b(15'h0);
		tick(1);
		note(1, v0);
		casc_din <= 72'({$random(seed), $random(seed)});
		{casc_use, addr_latch_en} <= 2'h3;
		bmf_fabric_model_inst.get_b(15'h0);
		tick(1);
		note(1, casc_din);
		note(5, v0);
		casc_use <= 1'h0;
		$display("half, sleep and cascade done");
		for (i = 0; i < 3; i++) begin
			e = {$random(seed), $random(seed)};
			enc_din <= e;
			tick(2);
			dec_din <= enc_dout ^ flips[i];
			tick(2);
			if (i < 2)
				note(3, {6'h0, i == 1, 1'h0, e});
			else
				note(4, 72'h1);
		end
		{split_read_write_mode, ecc_en} <= 2'h3;
		width_b <= BMF_W72;
		wmode_a <= BMF_WR_FIRST;
		bmf_fabric_model_inst.put_a(15'h1, 72'(e));
		bmf_fabric_model_inst.get_b(15'h1);
		tick(1);
		note(1, 72'(e));
		note(6, 72'h0);
		ecc_en <= 1'h0;
		// raw word with one flipped data bit, stored past the encoder
		bmf_fabric_model_inst.put_a(15'h1, dec_din ^ 72'h8);
		tick(1);
		ecc_en <= 1'h1;
		bmf_fabric_model_inst.get_b(15'h1);
		tick(1);
		note(1, 72'(e));
		note(6, 72'h2);
		{split_read_write_mode, ecc_en} <= 2'h0;
		$display("ecc done");
		fifo_mode <= 1'h1;
		width_b <= BMF_W18;
		{afull_thresh, aempty_thresh} <= {13'h0100, 13'h0100};
		tick(2);
		// the last write meets a full fifo and must vanish
		for (i = 0; i <= 1024; i++) begin
			v0 = 72'({$random(seed), $random(seed)}) & 72'hF_FFFF_FFFF;
			if (i < 1024)
				fq.push_back(v0[35:0]);
			bmf_fabric_model_inst.put_a(15'h0, v0);
		end
		tick(2);
		note(2, 72'hA);
		for (i = 0; i < 2048; i++) begin
			bmf_fabric_model_inst.get_b(15'h0);
			tick(1);
			note(1, 72'(fq[i / 2] >> (18 * (i % 2))) & 72'h3FFFF);
		end
		bmf_fabric_model_inst.get_b(15'h0);
		tick(2);
		note(1, 72'(fq[1023] >> 18));
		note(2, 72'h5);
		tick(1);
		$display("fifo done");
		stop_test();
	end
endmodule
`default_nettype wire
